// ==== digipot_pkg.sv ====
package digipot_pkg;

    localparam int SYNC_LEN = 3;
    localparam logic [5:0] ADDR_FIXED = 6'h16;
    localparam logic [7:0] WIPER_MIDSCALE = 8'h80;
    localparam logic [7:0] TAP_SHUTDOWN = 8'h00;
    localparam int INSTR_RESET_POS = 6;
    localparam int INSTR_SHUTDOWN_POS = 5;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] SYNC_RESET = 3'h7;
    localparam logic [7:0] BYTE_CLEAR = 8'h00;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_INSTR,
        ST_INSTR_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RACK,
        ST_IGNORE
    } bus_state_t;

endpackage

// ==== link_if.sv ====
`timescale 1ns/100ps
interface link_if;
    logic bit_tog;
    logic [7:0] bits;

    modport link_side (
        output bit_tog,
        output bits
    );

    modport core_side (
        input bit_tog,
        input bits
    );
endinterface

// ==== scl_bit_sampler.sv ====
`timescale 1ns/100ps
module scl_bit_sampler
    import digipot_pkg::*;
(
    input wire logic i_scl,
    input wire logic i_resetn,
    input wire logic i_sda,
    link_if.link_side lnk
);

    typedef struct packed {
        logic tog;
        logic [7:0] bits;
    } link_state_t;

    link_state_t q;
    link_state_t d;

    // Sample data on each clock rise, MSB first
    always_comb begin
        d = q;
        d.bits = {q.bits[6:0], i_sda};
        d.tog = ~q.tog;
    end

    always_ff @(posedge i_scl or negedge i_resetn) begin
        if (!i_resetn) begin
            q.tog <= 1'b0;
            q.bits <= BYTE_CLEAR;
        end else begin
            q <= d;
        end
    end

    assign lnk.bit_tog = q.tog;
    assign lnk.bits = q.bits;

endmodule // scl_bit_sampler

// ==== i2c_digipot_wiper_control.sv ====
`timescale 1ns/100ps
module i2c_digipot_wiper_control
    import digipot_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_address_select_pin,
    output logic o_sda_o,
    output logic o_sda_oe,
    output logic [7:0] o_tap_code,
    output logic o_shutdown
);

    typedef struct packed {
        logic [2:0] scl_sync;
        logic [2:0] sda_sync;
        logic [2:0] asel_sync;
        logic scl_f;
        logic sda_f;
        logic asel_f;
        logic [2:0] tog_sync;
        logic tog_f;
        bus_state_t st;
        logic [2:0] cnt;
        logic [7:0] tx;
        logic [7:0] wiper_register;
        logic shutdown_bit;
        logic [7:0] tap;
        logic sda_oe;
        logic sda_o;
    } core_state_t;

    core_state_t q;
    core_state_t d;

    link_if lnk ();

    scl_bit_sampler u_sampler (
        .i_scl(i_scl),
        .i_resetn(i_resetn),
        .i_sda(i_sda),
        .lnk(lnk.link_side)
    );

    // Filtered level moves once the last two stages agree
    function automatic logic sync_filter(
        input logic [2:0] stages,
        input logic cur
    );
        logic res;
        res = cur;
        if (stages[1] == stages[2]) begin
            res = stages[2];
        end
        return res;
    endfunction

    // Effective tap seen by the switch decoder
    function automatic logic [7:0] tap_of(
        input logic [7:0] code,
        input logic sd
    );
        logic [7:0] res;
        res = code;
        if (sd) begin
            res = TAP_SHUTDOWN;
        end
        return res;
    endfunction

    // Shift a level into its three-stage synchroniser
    function automatic logic [2:0] sync_step(
        input logic [2:0] stages,
        input logic pin
    );
        logic [2:0] res;
        res = {stages[1:0], pin};
        return res;
    endfunction

    // Bit counter advance within a byte
    function automatic logic [2:0] next_bit(
        input logic [2:0] cnt
    );
        logic [2:0] res;
        res = cnt + 3'h1;
        return res;
    endfunction

    // True on the eighth bit of a byte
    function automatic logic last_bit(
        input logic [2:0] cnt
    );
        logic res;
        res = cnt == BIT_LAST;
        return res;
    endfunction

    // Own address: fixed part and select level
    function automatic logic addr_hit(
        input logic [7:0] rx,
        input logic sel
    );
        logic res;
        res = rx[7:2] == ADDR_FIXED && rx[1] == sel;
        return res;
    endfunction

    // Open-drain pull for one read bit, MSB first
    function automatic logic drive_bit(
        input logic [7:0] tx,
        input logic [2:0] cnt
    );
        logic res;
        res = !tx[BIT_LAST - cnt];
        return res;
    endfunction

    logic scl_rise_ev;
    logic scl_fall_ev;
    logic start_ev;
    logic stop_ev;
    logic bit_ev;
    logic rx_bit;
    logic [7:0] rx_byte;
    logic addr_match;

    always_comb begin
        d = q;
        scl_rise_ev = 1'b0;
        scl_fall_ev = 1'b0;
        start_ev = 1'b0;
        stop_ev = 1'b0;
        bit_ev = 1'b0;
        rx_bit = lnk.bits[0];
        rx_byte = lnk.bits;
        addr_match = 1'b0;

        // Pin synchronisers
        d.scl_sync = sync_step(q.scl_sync, i_scl);
        d.sda_sync = sync_step(q.sda_sync, i_sda);
        d.asel_sync = sync_step(q.asel_sync, i_address_select_pin);
        d.scl_f = sync_filter(q.scl_sync, q.scl_f);
        d.sda_f = sync_filter(q.sda_sync, q.sda_f);
        d.asel_f = sync_filter(q.asel_sync, q.asel_f);
        scl_rise_ev = d.scl_f && !q.scl_f;
        scl_fall_ev = !d.scl_f && q.scl_f;

        // START and STOP: data edge while clock stays high
        if (q.scl_f && d.scl_f) begin
            start_ev = q.sda_f && !d.sda_f;
            stop_ev = !q.sda_f && d.sda_f;
        end

        // Bit event from the link domain
        d.tog_sync = sync_step(q.tog_sync, lnk.bit_tog);
        d.tog_f = sync_filter(q.tog_sync, q.tog_f);
        bit_ev = d.tog_f != q.tog_f;

        addr_match =
            addr_hit(rx_byte, q.asel_f);

        if (start_ev) begin
            d.st = ST_ADDR;
            d.cnt = BIT_FIRST;
            d.sda_oe = 1'b0;
            d.tx = BYTE_CLEAR;
        end else if (stop_ev) begin
            d.st = ST_IDLE;
            d.cnt = BIT_FIRST;
            d.sda_oe = 1'b0;
            d.tx = BYTE_CLEAR;
        end else begin
            if (bit_ev) begin
                case (q.st)
                    ST_ADDR: begin
                        if (last_bit(q.cnt)) begin
                            d.cnt = BIT_FIRST;
                            if (addr_match) begin
                                d.st = ST_ADDR_ACK;
                            end else begin
                                d.st = ST_IGNORE;
                            end
                        end else begin
                            d.cnt = next_bit(q.cnt);
                        end
                    end
                    ST_ADDR_ACK: begin
                        d.cnt = BIT_FIRST;
                        if (rx_byte[1]) begin
                            d.st = ST_RDATA;
                            d.tx = q.wiper_register;
                        end else begin
                            d.st = ST_INSTR;
                        end
                    end
                    ST_INSTR: begin
                        if (last_bit(q.cnt)) begin
                            d.cnt = BIT_FIRST;
                            d.st = ST_INSTR_ACK;
                            // Only midscale and shutdown bits decode
                            d.shutdown_bit =
                                rx_byte[INSTR_SHUTDOWN_POS];
                            if (rx_byte[INSTR_RESET_POS]) begin
                                d.wiper_register =
                                    WIPER_MIDSCALE;
                            end
                        end else begin
                            d.cnt = next_bit(q.cnt);
                        end
                    end
                    ST_INSTR_ACK: begin
                        d.cnt = BIT_FIRST;
                        d.st = ST_WDATA;
                    end
                    ST_WDATA: begin
                        if (last_bit(q.cnt)) begin
                            d.cnt = BIT_FIRST;
                            d.st = ST_WDATA_ACK;
                            // Stored even while shut down
                            d.wiper_register =
                                rx_byte;
                        end else begin
                            d.cnt = next_bit(q.cnt);
                        end
                    end
                    ST_WDATA_ACK: begin
                        // Further bytes keep the same instruction
                        d.cnt = BIT_FIRST;
                        d.st = ST_WDATA;
                    end
                    ST_RDATA: begin
                        if (last_bit(q.cnt)) begin
                            d.cnt = BIT_FIRST;
                            d.st = ST_RACK;
                        end else begin
                            d.cnt = next_bit(q.cnt);
                        end
                    end
                    ST_RACK: begin
                        d.cnt = BIT_FIRST;
                        if (rx_bit) begin
                            d.st = ST_IGNORE;
                        end else begin
                            d.st = ST_RDATA;
                            d.tx = q.wiper_register;
                        end
                    end
                    ST_IDLE: begin
                        d.st = ST_IDLE;
                    end
                    ST_IGNORE: begin
                        d.st = ST_IGNORE;
                    end
                    default: begin
                        d.st = ST_IDLE;
                        d.cnt = BIT_FIRST;
                    end
                endcase
            end

            // Drive changes only after the clock has fallen
            if (scl_fall_ev) begin
                case (d.st)
                    ST_ADDR_ACK: begin
                        d.sda_oe = 1'b1;
                    end
                    ST_INSTR_ACK: begin
                        d.sda_oe = 1'b1;
                    end
                    ST_WDATA_ACK: begin
                        d.sda_oe = 1'b1;
                    end
                    ST_RDATA: begin
                        d.sda_oe =
                            drive_bit(d.tx, d.cnt);
                    end
                    default: begin
                        d.sda_oe = 1'b0;
                    end
                endcase
            end
        end

        // Outputs follow the register once a byte has landed
        d.tap = tap_of(d.wiper_register, d.shutdown_bit);
        d.sda_o = 1'b0;
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            q.scl_sync <= SYNC_RESET;
            q.sda_sync <= SYNC_RESET;
            q.asel_sync <= 3'h0;
            q.scl_f <= 1'b1;
            q.sda_f <= 1'b1;
            q.asel_f <= 1'b0;
            q.tog_sync <= 3'h0;
            q.tog_f <= 1'b0;
            q.st <= ST_IDLE;
            q.cnt <= BIT_FIRST;
            q.tx <= BYTE_CLEAR;
            q.wiper_register <= WIPER_MIDSCALE;
            q.shutdown_bit <= 1'b0;
            q.tap <= WIPER_MIDSCALE;
            q.sda_oe <= 1'b0;
            q.sda_o <= 1'b0;
        end else begin
            q <= d;
        end
    end

    assign o_sda_o = q.sda_o;
    assign o_sda_oe = q.sda_oe;
    assign o_tap_code = q.tap;
    assign o_shutdown = q.shutdown_bit;

endmodule // i2c_digipot_wiper_control

// ==== digipot_sva.sv ====
`timescale 1ns/100ps
module digipot_sva
    import digipot_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_address_select_pin,
    input wire logic o_sda_o,
    input wire logic o_sda_oe,
    input wire logic [7:0] o_tap_code,
    input wire logic o_shutdown
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    logic scl_q;
    logic [3:0] rise_q;
    logic [3:0] fall_q;
    // Cycles since the last clock line edges, saturating
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            scl_q <= 1'b1;
            rise_q <= 4'hF;
            fall_q <= 4'hF;
        end else begin
            scl_q <= i_scl;
            rise_q <= (i_scl && !scl_q) ? 4'h0 :
                rise_q + {3'h0, rise_q != 4'hF};
            fall_q <= (!i_scl && scl_q) ? 4'h0 :
                fall_q + {3'h0, fall_q != 4'hF};
        end
    end
    sequence s_oe_on;
        o_sda_oe [*3];
    endsequence
    sequence s_oe_off;
        !o_sda_oe [*3];
    endsequence
    property p_sda_o;
        o_sda_o == 1'b0;
    endproperty
    property p_oe_timing;
        $changed(o_sda_oe) |-> !i_scl && fall_q < 4'h8;
    endproperty
    property p_oe_hold;
        $rose(i_scl) && o_sda_oe |-> s_oe_on;
    endproperty
    property p_oe_off;
        $rose(i_scl) && !o_sda_oe |-> s_oe_off;
    endproperty
    property p_sd_tap;
        o_shutdown |-> o_tap_code == 8'h00;
    endproperty
    property p_tap_rise;
        $changed(o_tap_code) |-> rise_q < 4'hC;
    endproperty
    property p_sd_rise;
        $changed(o_shutdown) |-> rise_q < 4'hC;
    endproperty
    property p_reset;
        $rose(i_resetn) |-> o_tap_code == 8'h80 && !o_shutdown && !o_sda_oe;
    endproperty
    a_sda_o: assert property (p_sda_o)
        else $error("data pin driven high");
    a_oe_timing: assert property (p_oe_timing)
        else $error("data drive changed outside clock low");
    a_oe_hold: assert property (p_oe_hold)
        else $error("data drive dropped in clock high");
    a_oe_off: assert property (p_oe_off)
        else $error("data drive started in clock high");
    a_sd_tap: assert property (p_sd_tap)
        else $error("tap not at bottom in shutdown");
    a_tap_rise: assert property (p_tap_rise)
        else $error("tap changed away from a bit");
    a_sd_rise: assert property (p_sd_rise)
        else $error("shutdown changed away from a bit");
    a_reset: assert property (p_reset)
        else $error("wrong values after reset");
endmodule // digipot_sva

bind i2c_digipot_wiper_control digipot_sva u_digipot_sva (.i_mclk,
    .i_resetn, .i_scl, .i_sda, .i_address_select_pin, .o_sda_o,
    .o_sda_oe, .o_tap_code, .o_shutdown);

// ==== i2c_master_model.sv ====
`timescale 1ns/100ps
module i2c_master_model (
    output logic o_scl,
    output logic o_sda,
    input wire logic i_sda
);
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    // One clock: 30 ns low, 15 ns high; sample at the rise
    task automatic clk(input logic b, output logic s);
        #7 o_sda = b;
        #23 o_scl = 1'b1;
        s = i_sda;
        #15 o_scl = 1'b0;
    endtask
    task automatic start();
        #30 o_sda = 1'b0;
        #30 o_scl = 1'b0;
    endtask
    task automatic stop();
        #7 o_sda = 1'b0;
        #23 o_scl = 1'b1;
        #30 o_sda = 1'b1;
        #30;
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk(d[i], s);
        clk(1'b1, s);
        ack = !s;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) clk(1'b1, d[i]);
        clk(last, s);
    endtask
endmodule // i2c_master_model

// ==== testbench.sv ====
`timescale 1ns/100ps
module testbench;
    import digipot_pkg::*;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic sel = 1'b0;
    logic scl;
    logic msda;
    wire logic sda;
    logic sda_o;
    logic sda_oe;
    logic [7:0] tap;
    logic sd;
    int wiper = 128;
    logic shut = 1'b0;
    int fails = 0;
    int samples_checked = 0;
    assign sda = msda & ~(sda_oe & ~sda_o);
    always #2.5 mclk = ~mclk;
    i2c_master_model u_i2c_master_model (.o_scl(scl), .o_sda(msda),
        .i_sda(sda));
    i2c_digipot_wiper_control u_i2c_digipot_wiper_control (.i_mclk(mclk),
        .i_resetn(resetn), .i_scl(scl), .i_sda(sda),
        .i_address_select_pin(sel), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
        .o_tap_code(tap), .o_shutdown(sd));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            fails++;
        end
    endtask
    task automatic conclude();
        if (fails == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic settle();
        repeat (10) @(negedge mclk);
        chk(tap, shut ? 8'h00 : wiper[7:0]);
        chk(sd, shut);
    endtask
    // Write with own address (m=1) or the other one (m=0)
    task automatic wr(input logic m, input logic [7:0] ins, input int n);
        logic a;
        logic [7:0] d;
        u_i2c_master_model.start();
        u_i2c_master_model.wbyte({ADDR_FIXED, sel ^ !m, 1'b0}, a);
        chk(a, m);
        u_i2c_master_model.wbyte(ins, a);
        chk(a, m);
        if (m) begin
            if (ins[6]) wiper = 128;
            shut = ins[5];
        end
        settle();
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            u_i2c_master_model.wbyte(d, a);
            chk(a, m);
            if (m) wiper = d;
            settle();
        end
        u_i2c_master_model.stop();
    endtask
    task automatic rd(input int n);
        logic a;
        logic [7:0] d;
        u_i2c_master_model.start();
        u_i2c_master_model.wbyte({ADDR_FIXED, sel, 1'b1}, a);
        chk(a, 1'b1);
        for (int i = 0; i < n; i++) begin
            u_i2c_master_model.rbyte(i == n - 1, d);
            chk(d, wiper[7:0]);
        end
        u_i2c_master_model.stop();
    endtask
    task automatic abort_wr();
        logic a;
        u_i2c_master_model.start();
        u_i2c_master_model.wbyte({ADDR_FIXED, sel, 1'b0}, a);
        u_i2c_master_model.wbyte(8'h00, a);
        shut = 1'b0;
        for (int i = 0; i < 4; i++) u_i2c_master_model.clk(1'b0, a);
        u_i2c_master_model.stop();
        settle();
    endtask
    initial begin
        #500000;
        fails++;
        conclude();
    end
    initial begin
        void'($urandom(32'h90E6E93E));
        repeat (12) @(negedge mclk);
        chk(tap, 8'h80);
        chk(sd, 1'b0);
        resetn = 1'b1;
        for (int k = 0; k < 2; k++) begin
            sel = k[0];
            repeat (8) @(negedge mclk);
            wr(1'b1, 8'h00, 3);
            rd(2);
            wr(1'b0, 8'h00, 1);
            wr(1'b1, 8'h20, 2);
            rd(1);
            wr(1'b1, 8'h9F, 0);
            wr(1'b1, 8'hDF, 0);
            wr(1'b1, 8'h40, 1);
            abort_wr();
            rd(1);
        end
        conclude();
    end
endmodule // testbench
